// ### hdl/aod_pkg.sv
package aod_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_CHSTAT = 8'h08;

  // ==========================================================
  // control field positions
  localparam int CTL_OLT_EN   = 0;
  localparam int CTL_BLEED    = 1;
  localparam int CTL_LDM      = 2;
  localparam int CTL_HF_SEL   = 3;
  localparam int CTL_HCL      = 4;
  localparam int CTL_LC_ROUTE = 5;
  localparam int CTL_WRN_RTE  = 6;
  localparam int CTL_SD_RTE   = 7;
  localparam int CTL_DIST_LO  = 8;
  localparam int CTL_TWT_LO   = 10;
  localparam int CTL_LMODE_LO = 12;
  localparam int CTL_UMODE_LO = 14;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // ==========================================================
  // thresholds in analog comparator units
  localparam logic [11:0] OPEN_LIM_LINE   = 12'd300;
  localparam logic [11:0] OPEN_LIM_SPKR   = 12'd100;
  localparam logic [11:0] TEMP_WARN_BASE  = 12'd110;
  localparam logic [11:0] TEMP_WARN_STEP  = 12'd10;
  localparam logic [11:0] TEMP_SD_HI      = 12'd150;
  localparam logic [11:0] TEMP_SD_LO      = 12'd140;
  // pump levels need 13 bits: 4100 mV does not fit in 12
  localparam logic [12:0] PUMP_UV_MV      = 13'd3870;
  localparam logic [12:0] PUMP_OK_MV      = 13'd4100;
  localparam logic [11:0] OFFSET_LIM_MV   = 12'd1000;
  localparam int          HF_DIVIDE_SHIFT = 2;
  localparam logic [1:0]  MODE_TRISTATE   = 2'b00;

  // ==========================================================
  // per-channel analog inputs
  typedef struct packed {
    logic [11:0] load_ohm;
    logic [11:0] load_ma;
    logic [11:0] offset_mv;
    logic [1:0]  dist_pct_code;
    logic        pos_high;
  } aod_chan_t;

  // per-channel drive controls
  typedef struct packed {
    logic neg_low_on;
    logic others_on;
    logic src_2ma;
    logic out_en;
  } aod_drive_t;
endpackage : aod_pkg

// ### hdl/aod_diag.sv
`timescale 1ns/1ps
// Notes on behaviour
// - open test limit is 100 or 300 ohms by line-driver mode bit
// - during open test only negative low sides on, 2mA source on
// - positive output high during test marks that channel open
// - in play with select 0, trip flag set when current over threshold
// - trip flags are not latched and follow current
// - with low-current route on, clip pin is NOR of trip flags
// - high-frequency select quarters the trip threshold
// - offset, clip, thermal and supply flags refresh continuously
// - offset flag per channel shows offset beyond about 1V
// - two-bit select picks 1, 3, 5 or 10 percent clip level
// - saturation flag reads 0 while clipping; clip pins show it
// - warning flag low above limit, no action, self clearing
// - warning limit 110 to 140 degrees in 10 degree steps
// - above 150 shut channels, flag low; resume below 140
// - shutdown route enable puts shutdown flag on fault pin
// - pump below 3.87V sets undervoltage flag, three-states outputs
// - pump flag released only above 4.1V
// - warning and shutdown route bits drive the fault pin
module aod_diag #(
  parameter int NCH = 4
) (
  input  wire logic                  i_clk,          // 50 MHz
  input  wire logic                  i_sys_rst,      // sync, high
  input  wire logic [31:0]           s_axi_awaddr,   // write address
  input  wire logic                  s_axi_awvalid,  // aw valid
  output logic                       s_axi_awready,  // aw ready
  input  wire logic [31:0]           s_axi_wdata,    // write data
  input  wire logic [3:0]            s_axi_wstrb,    // byte enables
  input  wire logic                  s_axi_wvalid,   // w valid
  output logic                       s_axi_wready,   // w ready
  output logic [1:0]                 s_axi_bresp,    // write resp
  output logic                       s_axi_bvalid,   // b valid
  input  wire logic                  s_axi_bready,   // b ready
  input  wire logic [31:0]           s_axi_araddr,   // read address
  input  wire logic                  s_axi_arvalid,  // ar valid
  output logic                       s_axi_arready,  // ar ready
  output logic [31:0]                s_axi_rdata,    // read data
  output logic [1:0]                 s_axi_rresp,    // read resp
  output logic                       s_axi_rvalid,   // r valid
  input  wire logic                  s_axi_rready,   // r ready
  input  wire aod_pkg::aod_chan_t [NCH-1:0] i_chan,  // channel sense
  input  wire logic [11:0]           i_temp_c,       // die temp
  input  wire logic [12:0]           i_pump_mv,      // hold voltage
  input  wire logic [11:0]           i_trip_ma,      // base trip level
  output aod_pkg::aod_drive_t [NCH-1:0] o_drive,     // output drive
  output logic                       o_clip_fault_pin_oe, // high = pull
  output logic                       o_mute_or_clip_pin_oe, // high = pull
  output logic                       o_fault_pin_oe  // high = pull
);

  // ==========================================================
  // input synchronisers
  aod_pkg::aod_chan_t [NCH-1:0] chan_m_q, chan_q;
  logic [11:0] temp_m_q, temp_q, trip_m_q, trip_q;
  logic [12:0] pump_m_q, pump_q;

  always_ff @(posedge i_clk) begin
    chan_m_q <= i_chan;
    chan_q   <= chan_m_q;
    temp_m_q <= i_temp_c;
    temp_q   <= temp_m_q;
    pump_m_q <= i_pump_mv;
    pump_q   <= pump_m_q;
    trip_m_q <= i_trip_ma;
    trip_q   <= trip_m_q;
  end

  // ==========================================================
  // axi4-lite slave
  logic [15:0] ctrl_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] stat_word, chstat_word;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl_q       <= aod_pkg::CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == aod_pkg::ADDR_CTRL) begin
          s_axi_bresp <= 2'b00;
          if (wstrb_q[0]) ctrl_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) ctrl_q[15:8] <= wdata_q[15:8];
        end else if (awaddr_q == aod_pkg::ADDR_STAT ||
                     awaddr_q == aod_pkg::ADDR_CHSTAT) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      if (s_axi_araddr[7:0] == aod_pkg::ADDR_CTRL) begin
        s_axi_rdata <= {16'h0000, ctrl_q};
      end else if (s_axi_araddr[7:0] == aod_pkg::ADDR_STAT) begin
        s_axi_rdata <= stat_word;
      end else if (s_axi_araddr[7:0] == aod_pkg::ADDR_CHSTAT) begin
        s_axi_rdata <= chstat_word;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // control decode
  logic       olt_en, ldm, hf_sel, lc_route, wrn_route, sd_route;
  logic [1:0] dist_sel, twt_sel, lmode, umode;

  assign olt_en    = ctrl_q[aod_pkg::CTL_OLT_EN];
  assign ldm       = ctrl_q[aod_pkg::CTL_LDM];
  assign hf_sel    = ctrl_q[aod_pkg::CTL_HF_SEL];
  assign lc_route  = ctrl_q[aod_pkg::CTL_LC_ROUTE];
  assign wrn_route = ctrl_q[aod_pkg::CTL_WRN_RTE];
  assign sd_route  = ctrl_q[aod_pkg::CTL_SD_RTE];
  assign dist_sel  = ctrl_q[aod_pkg::CTL_DIST_LO +: 2];
  assign twt_sel   = ctrl_q[aod_pkg::CTL_TWT_LO +: 2];
  assign lmode     = ctrl_q[aod_pkg::CTL_LMODE_LO +: 2];
  assign umode     = ctrl_q[aod_pkg::CTL_UMODE_LO +: 2];

  // ==========================================================
  // status flags, active-low where the hardware reports them so
  logic [NCH-1:0] load_ok_q, trip_q_f, offset_ok_q, sat_q;
  logic           warn_n_q, sd_n_q, pump_uv_q;
  logic [11:0]    trip_lim, warn_lim, open_lim;

  assign trip_lim = hf_sel ? (trip_q >> aod_pkg::HF_DIVIDE_SHIFT)
                           : trip_q;
  assign warn_lim = aod_pkg::TEMP_WARN_BASE +
                    12'(twt_sel) * aod_pkg::TEMP_WARN_STEP;
  assign open_lim = ldm ? aod_pkg::OPEN_LIM_LINE : aod_pkg::OPEN_LIM_SPKR;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          load_ok_q[g]   <= 1'b1;
          trip_q_f[g]    <= 1'b0;
          offset_ok_q[g] <= 1'b1;
          sat_q[g]       <= 1'b1;
        end else begin
          if (olt_en) begin
            load_ok_q[g] <= !(chan_q[g].pos_high ||
                              chan_q[g].load_ohm > open_lim);
          end
          trip_q_f[g] <= chan_q[g].load_ma > trip_lim;
          offset_ok_q[g] <= chan_q[g].offset_mv <= aod_pkg::OFFSET_LIM_MV;
          sat_q[g] <= chan_q[g].dist_pct_code < dist_sel;
        end
      end

      always_comb begin
        o_drive[g].neg_low_on = olt_en;
        o_drive[g].others_on  = 1'b0;
        o_drive[g].src_2ma    = olt_en;
        o_drive[g].out_en     = !olt_en && sd_n_q && !pump_uv_q &&
          (((g < 2) ? lmode : umode) != aod_pkg::MODE_TRISTATE);
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) warn_n_q <= 1'b1;
    else warn_n_q <= !(temp_q > warn_lim);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) sd_n_q <= 1'b1;
    else if (temp_q > aod_pkg::TEMP_SD_HI) sd_n_q <= 1'b0;
    else if (temp_q < aod_pkg::TEMP_SD_LO) sd_n_q <= 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) pump_uv_q <= 1'b0;
    else if (pump_q < aod_pkg::PUMP_UV_MV) pump_uv_q <= 1'b1;
    else if (pump_q > aod_pkg::PUMP_OK_MV) pump_uv_q <= 1'b0;
  end

  assign stat_word   = {29'h0, pump_uv_q, sd_n_q, warn_n_q};
  assign chstat_word = {16'h0, sat_q, offset_ok_q, trip_q_f, load_ok_q};

  // ==========================================================
  // open-drain pins
  // clip pin
  assign o_clip_fault_pin_oe = (lc_route && (|trip_q_f)) || !(&sat_q);
  assign o_mute_or_clip_pin_oe = !(&sat_q);
  assign o_fault_pin_oe = (sd_route && !sd_n_q) || (wrn_route && !warn_n_q);

  // ==========================================================
  // checks
  property p_sd_hyst;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!sd_n_q && temp_q >= aod_pkg::TEMP_SD_LO) |=> !sd_n_q;
  endproperty
  a_sd_hyst: assert property (p_sd_hyst)
    else $error("shutdown released above low limit");

  property p_pump_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      (pump_uv_q && pump_q <= aod_pkg::PUMP_OK_MV) |=> pump_uv_q;
  endproperty
  a_pump_hold: assert property (p_pump_hold)
    else $error("pump flag released early");

  property p_pump_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      pump_uv_q |-> !o_drive[0].out_en;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("output enabled under pump undervoltage");

  property p_clip_nor;
    @(posedge i_clk) disable iff (i_sys_rst)
      (lc_route && |trip_q_f) |-> o_clip_fault_pin_oe;
  endproperty
  a_clip_nor: assert property (p_clip_nor)
    else $error("clip pin not pulled on trip");

  property p_fault_sd;
    @(posedge i_clk) disable iff (i_sys_rst)
      (sd_route && !sd_n_q) |-> o_fault_pin_oe;
  endproperty
  a_fault_sd: assert property (p_fault_sd)
    else $error("shutdown not on fault pin");

  property p_olt_drive;
    @(posedge i_clk) disable iff (i_sys_rst)
      olt_en |-> (o_drive[0].neg_low_on && o_drive[0].src_2ma &&
                  !o_drive[0].others_on);
  endproperty
  a_olt_drive: assert property (p_olt_drive)
    else $error("open test drive wrong");

  property p_trip_follow;
    @(posedge i_clk) disable iff (i_sys_rst)
      (chan_q[0].load_ma <= trip_lim) |=> !trip_q_f[0];
  endproperty
  a_trip_follow: assert property (p_trip_follow)
    else $error("trip flag latched");

  property p_warn_follow;
    @(posedge i_clk) disable iff (i_sys_rst)
      (temp_q > warn_lim) |=> !warn_n_q;
  endproperty
  a_warn_follow: assert property (p_warn_follow)
    else $error("warning not raised");

endmodule : aod_diag

// ### bench/aod_pin_pullup.sv
`timescale 1ns/1ps
module aod_pin_pullup (
  input  wire logic [2:0] i_pin_oe, // pull-down enables
  output logic      [2:0] o_pin     // resolved pin level
);
  // ==========================================================
  // host side pull-ups
  // open drain resolve
  assign o_pin = ~i_pin_oe;
endmodule : aod_pin_pullup

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                      i_clk;
  logic                      i_sys_rst;
  logic [31:0]               awaddr, wdata, araddr, rdata, d;
  logic                      awvalid, awready, wvalid, wready, bvalid;
  logic                      bready, arvalid, arready, rvalid, rready;
  logic [1:0]                bresp, rresp;
  aod_pkg::aod_chan_t [3:0]  ch;
  aod_pkg::aod_drive_t [3:0] drv;
  logic [11:0]               temp, trip, lim;
  logic [12:0]               pump;
  logic [2:0]                oe, pin;
  logic [3:0]                e;
  logic                      c;
  int                        num_errors, samples_checked;

  aod_diag dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .i_chan(ch), .i_temp_c(temp),
    .i_pump_mv(pump), .i_trip_ma(trip), .o_drive(drv),
    .o_clip_fault_pin_oe(oe[0]), .o_mute_or_clip_pin_oe(oe[1]),
    .o_fault_pin_oe(oe[2]));
  aod_pin_pullup host (.i_pin_oe(oe), .o_pin(pin));
  // ==========================================================
  // bench tasks
  task automatic finish_test;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 200) begin
      num_errors++;
      finish_test();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int   n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_clk);
    awaddr  <= {24'h000000, a};
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd && bvalid) && n < 200);
    bready <= 1'b0;
    tmo(n);
    chk(32'(bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clk);
    araddr  <= {24'h000000, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid && n < 200);
    d = rdata;
    rready <= 1'b0;
    tmo(n);
    chk(32'(rresp), 32'(er));
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] x);
    rd(a, 2'b00);
    chk(d & m, x);
  endtask : rdchk

  task automatic settle;
    repeat (4) @(posedge i_clk);
  endtask : settle

  // ==========================================================
  // clock and sequence
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    num_errors = 0;
    samples_checked = 0;
    i_sys_rst = 1'b1;
    ch = '0;
    for (int i = 0; i < 4; i++) begin
      ch[i].load_ohm = 12'h064;
    end
    temp = 12'h019;
    pump = 13'h0FFF;
    trip = 12'h064;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdchk(8'h00, 32'hFFFFFFFF, 32'h00000000);
    rdchk(8'h04, 32'h00000007, 32'h00000003);
    wr(8'h04, 32'h0000FFFF, 2'b00);
    rdchk(8'h04, 32'h00000007, 32'h00000003);
    wr(8'h0C, 32'h00000001, 2'b10);
    rd(8'h0C, 2'b10);
    chk(d, 32'h00000000);
    ch[1].load_ohm <= 12'h096;
    ch[2].load_ohm <= 12'h12C;
    ch[3].pos_high <= 1'b1;
    wr(8'h00, 32'h00005000, 2'b00);
    wr(8'h00, 32'h00000000, 2'b00);
    for (int l = 0; l < 2; l++) begin
      lim = (l == 1) ? 12'h12C : 12'h064;
      for (int i = 0; i < 4; i++) begin
        e[i] = !(ch[i].load_ohm > lim || ch[i].pos_high);
      end
      wr(8'h00, 32'h00000003 | (32'(l) << 2), 2'b00);
      repeat (10000) @(posedge i_clk);
      chk(32'(drv), 32'h0000AAAA);
      rdchk(8'h08, 32'h0000000F, 32'(e));
      wr(8'h00, 32'h00000000, 2'b00);
    end
    ch[0].load_ma <= 12'h032;
    ch[1].load_ma <= 12'h096;
    ch[2].load_ma <= 12'h01E;
    ch[3].load_ma <= 12'h05A;
    for (int hf = 0; hf < 2; hf++) begin
      lim = (hf == 1) ? 12'h019 : 12'h064;
      wr(8'h00, 32'h0000F320 | (32'(hf) << 3), 2'b00);
      settle();
      for (int i = 0; i < 4; i++) begin
        e[i] = ch[i].load_ma > lim;
      end
      rdchk(8'h08, 32'h000000F0, 32'(e) << 4);
      chk(32'(pin[0]), 32'(!(|e)));
      chk(32'(drv), 32'h00001111);
    end
    for (int i = 0; i < 4; i++) begin
      ch[i].load_ma <= 12'h000;
      ch[i].dist_pct_code <= 2'b10;
    end
    settle();
    rdchk(8'h08, 32'h000000F0, 32'h00000000);
    chk(32'(pin[0]), 32'h00000001);
    wr(8'h00, 32'h0000F300, 2'b00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'h0000F000 | (32'(s) << 8), 2'b00);
      settle();
      c = (s <= 2);
      rdchk(8'h08, 32'h0000F000, c ? 32'h0 : 32'hF000);
      chk(32'(pin[1]), 32'(!c));
      chk(32'(pin[0]), 32'(!c));
    end
    ch[0].offset_mv <= 12'h3E9;
    ch[1].offset_mv <= 12'h3E8;
    for (int i = 0; i < 4; i++) begin
      ch[i].dist_pct_code <= 2'b00;
    end
    settle();
    rdchk(8'h08, 32'h00000F00, 32'h00000E00);
    for (int t = 0; t < 4; t++) begin
      lim = 12'h06E + 12'h00A * 12'(t);
      wr(8'h00, 32'h0000F340 | (32'(t) << 10), 2'b00);
      temp <= lim + 12'h001;
      settle();
      rdchk(8'h04, 32'h00000001, 32'h00000000);
      chk(32'(pin[2]), 32'h00000000);
      temp <= lim;
      settle();
      rdchk(8'h04, 32'h00000001, 32'h00000001);
      chk(32'(pin[2]), 32'h00000001);
    end
    wr(8'h00, 32'h0000F380, 2'b00);
    temp <= 12'h097;
    settle();
    rdchk(8'h04, 32'h00000002, 32'h00000000);
    chk(32'(drv), 32'h00000000);
    chk(32'(pin[2]), 32'h00000000);
    temp <= 12'h091;
    settle();
    rdchk(8'h04, 32'h00000002, 32'h00000000);
    temp <= 12'h08B;
    settle();
    rdchk(8'h04, 32'h00000002, 32'h00000002);
    chk(32'(drv), 32'h00001111);
    pump <= 13'h0F14;
    settle();
    rdchk(8'h04, 32'h00000004, 32'h00000004);
    chk(32'(drv), 32'h00000000);
    pump <= 13'h0FA0;
    settle();
    rdchk(8'h04, 32'h00000004, 32'h00000004);
    pump <= 13'h0FFF;
    settle();
    rdchk(8'h04, 32'h00000004, 32'h00000004);
    pump <= 13'h1005;
    settle();
    rdchk(8'h04, 32'h00000004, 32'h00000000);
    chk(32'(drv), 32'h00001111);
    finish_test();
  end
endmodule : testbench
